// [pmt_map.vh]
// register offsets, field layout, reset values and type encodings of the page memory type resolver
`ifndef PMT_MAP_VH
`define PMT_MAP_VH

// ==========================================================
// register offsets (byte addresses)
`define PMT_OFF_TABLE_LO      12'h000
`define PMT_OFF_TABLE_HI      12'h004
`define PMT_OFF_STATUS        12'h008
`define PMT_OFF_RANGE_CTRL    12'h00c
`define PMT_OFF_FEATURE       12'h010

// ==========================================================
// memory type encodings
`define PMT_TYPE_UC           3'h0
`define PMT_TYPE_WC           3'h1
`define PMT_TYPE_WT           3'h4
`define PMT_TYPE_WP           3'h5
`define PMT_TYPE_WB           3'h6
`define PMT_TYPE_UCM          3'h7
`define PMT_EFF_CD            4'h8
`define PMT_TYPE_W            3

// ==========================================================
// field layout
`define PMT_SLOT_W            8
`define PMT_SLOT_RSV_MASK     8'hf8
`define PMT_TABLE_RESET       64'h0007040600070406
`define PMT_FEATURE_BIT       16
`define PMT_LEAF_SEL_BIT      7
`define PMT_DIR_SEL_BIT       12
`define PMT_INHIBIT_BIT       4
`define PMT_WTHRU_BIT         3

// ==========================================================
// status bits
`define PMT_ST_FAULT          0
`define PMT_ST_PENDING        1

// ==========================================================
// range control fields
`define PMT_RC_ENABLE         3

// ==========================================================
// allocation states reported to the cache
`define PMT_ALLOC_NONE        2'h0
`define PMT_ALLOC_SHARED      2'h1
`define PMT_ALLOC_SH_EXCL     2'h2
`define PMT_ALLOC_MODIFIED    2'h3

`endif

// [pmt_merge.v]
// effective memory type merge of table type and range type
`timescale 1ns/10ps
`default_nettype none
`include "pmt_map.vh"

module pmt_merge (
  input  wire [2:0] table_type,
  input  wire [2:0] range_type,
  output reg  [3:0] eff_type
);

  // ==========================================================
  // merge table
  // combine table type with range type
  always @* begin
    eff_type = {1'b0, range_type};
    case (table_type)
      `PMT_TYPE_UC: begin
        eff_type = (range_type == `PMT_TYPE_UC) ? 4'h0 : `PMT_EFF_CD;
      end
      `PMT_TYPE_UCM: begin
        if (range_type == `PMT_TYPE_UC)
          eff_type = 4'h0;
        else if (range_type == `PMT_TYPE_WC)
          eff_type = {1'b0, `PMT_TYPE_WC};
        else
          eff_type = `PMT_EFF_CD;
      end
      `PMT_TYPE_WC: begin
        eff_type = {1'b0, `PMT_TYPE_WC};
      end
      `PMT_TYPE_WP: begin
        if (range_type == `PMT_TYPE_UC)
          eff_type = 4'h0;
        else if (range_type == `PMT_TYPE_WP || range_type == `PMT_TYPE_WB)
          eff_type = {1'b0, `PMT_TYPE_WP};
        else
          eff_type = `PMT_EFF_CD;
      end
      `PMT_TYPE_WT: begin
        if (range_type == `PMT_TYPE_UC)
          eff_type = 4'h0;
        else if (range_type == `PMT_TYPE_WT || range_type == `PMT_TYPE_WB)
          eff_type = {1'b0, `PMT_TYPE_WT};
        else
          eff_type = `PMT_EFF_CD;
      end
      default: begin
        eff_type = {1'b0, range_type};
      end
    endcase
  end

endmodule // pmt_merge
`default_nettype wire

// [pmt_resolver.v]
// page memory type resolver: attribute table, lookup, merge, cache policy, apb slave
// ==========================================================
`timescale 1ns/10ps
`default_nettype none
`include "pmt_map.vh"

module pmt_resolver #(
  parameter ENTRY_W = 64
) (
  input  wire               pclk,
  input  wire               presetn,
  // apb slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [11:0]        paddr,
  input  wire [31:0]        pwdata,
  input  wire [3:0]         pstrb,
  output wire               pready,
  output reg  [31:0]        prdata,
  output wire               pslverr,
  // translation request from the walker
  input  wire               xlat_valid,
  input  wire [ENTRY_W-1:0] xlat_entry,
  input  wire [1:0]         xlat_level,
  input  wire [2:0]         xlat_range_type,
  input  wire               xlat_is_write,
  // lookup answer to the cache path
  output reg                type_valid,
  output reg  [3:0]         eff_type_out,
  output reg  [2:0]         table_type_out,
  output reg                cacheable_out,
  output reg                combine_ok_out,
  output reg                speculate_ok_out,
  output reg  [1:0]         alloc_state_out,
  output reg                write_mem_out,
  output reg                write_cache_out,
  output reg                write_inval_out,
  output reg                protection_fault
);

  // walk level codes
  localparam [1:0] LVL_LEAF  = 2'h0;
  localparam [1:0] LVL_DIR   = 2'h1;
  localparam [1:0] LVL_UPPER = 2'h2;

  // ==========================================================
  // functions
  // true when an encoding is one of the supported types
  function type_ok;
    input [7:0] slot;
    begin
      type_ok = ((slot & `PMT_SLOT_RSV_MASK) == 8'h00) &&
                (slot[2:0] != 3'h2) && (slot[2:0] != 3'h3);
    end
  endfunction

  // check a 32-bit half of the table, four slots
  function half_ok;
    input [31:0] half;
    begin
      half_ok = type_ok(half[7:0]) && type_ok(half[15:8]) &&
                type_ok(half[23:16]) && type_ok(half[31:24]);
    end
  endfunction

  // byte-lane merge of write data into a word
  function [31:0] lane_merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  strb;
    integer i;
    begin
      lane_merge = old_w;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          lane_merge[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
  endfunction

  // ==========================================================
  // registers
  reg  [63:0] table_reg;
  reg  [63:0] table_next;
  reg         fault_reg;
  reg         range_en_reg;
  reg  [2:0]  range_def_reg;
  reg         fault_set;
  reg  [2:0]  sel_reg;
  reg  [2:0]  range_reg;
  reg         wr_reg;
  reg         pend_reg;

  wire        access   = psel && penable;
  wire        wr_acc   = access && pwrite;
  wire        rd_setup = psel && !penable && !pwrite;
  wire        hit_lo   = (paddr == `PMT_OFF_TABLE_LO);
  wire        hit_hi   = (paddr == `PMT_OFF_TABLE_HI);
  wire        hit_st   = (paddr == `PMT_OFF_STATUS);
  wire        hit_rc   = (paddr == `PMT_OFF_RANGE_CTRL);
  wire        hit_ft   = (paddr == `PMT_OFF_FEATURE);
  wire        mapped   = hit_lo || hit_hi || hit_st || hit_rc || hit_ft;
  wire [31:0] lo_new   = lane_merge(table_reg[31:0], pwdata, pstrb);
  wire [31:0] hi_new   = lane_merge(table_reg[63:32], pwdata, pstrb);

  // zero wait states; error for any unmapped access or a faulting write
  assign pready  = 1'b1;
  assign pslverr = access && (!mapped || fault_set);

  // ==========================================================
  // table write check
  // candidate value and fault on bad encodings
  // a rejected write leaves the whole half untouched
  always @* begin
    table_next = table_reg;
    fault_set  = 1'b0;
    if (wr_acc && hit_lo) begin
      if (half_ok(lo_new))
        table_next[31:0] = lo_new;
      else
        fault_set = 1'b1;
    end else if (wr_acc && hit_hi) begin
      if (half_ok(hi_new))
        table_next[63:32] = hi_new;
      else
        fault_set = 1'b1;
    end else if (wr_acc && (hit_st || hit_ft)) begin
      fault_set = 1'b0; // no fault: feature is read-only, a status write only clears the fault bit
    end
  end

  // ==========================================================
  // register file update
  // table, status and range control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_reg     <= `PMT_TABLE_RESET;
      fault_reg     <= 1'b0;
      range_en_reg  <= 1'b0;
      range_def_reg <= 3'h0;
    end else begin
      table_reg <= table_next;
      // sticky fault: set wins over clear
      if (fault_set)
        fault_reg <= 1'b1;
      else if (wr_acc && hit_st && pwdata[`PMT_ST_FAULT])
        fault_reg <= 1'b0;
      if (wr_acc && hit_rc) begin
        range_def_reg <= pwdata[2:0];
        range_en_reg  <= pwdata[`PMT_RC_ENABLE];
      end
    end
  end

  // fault pulse toward the core
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      protection_fault <= 1'b0;
    else
      protection_fault <= fault_set;
  end

  // ==========================================================
  // read data
  // read mux, looked up while a read is in its setup phase
  reg  [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (rd_setup) begin
      if (hit_lo)
        rd_mux = table_reg[31:0];
      else if (hit_hi)
        rd_mux = table_reg[63:32];
      else if (hit_st)
        rd_mux = {30'h0, pend_reg, fault_reg};
      else if (hit_rc)
        rd_mux = {28'h0, range_en_reg, range_def_reg};
      else if (hit_ft)
        rd_mux = 32'h00000001 << `PMT_FEATURE_BIT;
    end
  end

  // read data register: loaded at the setup edge, stands through the access
  // phase and falls back to zero after it, so no stale word lingers on the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else
      prdata <= rd_mux;
  end

  // ==========================================================
  // index capture
  // pick select bits by level of the walk entry
  reg  [2:0] sel_next;
  always @* begin
    sel_next = 3'h0;
    case (xlat_level)
      LVL_LEAF: begin
        sel_next = {xlat_entry[`PMT_LEAF_SEL_BIT], xlat_entry[`PMT_INHIBIT_BIT],
                    xlat_entry[`PMT_WTHRU_BIT]};
      end
      LVL_DIR: begin
        sel_next = {xlat_entry[`PMT_DIR_SEL_BIT], xlat_entry[`PMT_INHIBIT_BIT],
                    xlat_entry[`PMT_WTHRU_BIT]};
      end
      default: begin
        sel_next = {1'b0, xlat_entry[`PMT_INHIBIT_BIT], xlat_entry[`PMT_WTHRU_BIT]};
      end
    endcase
  end

  // latch the index and range type during translation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg   <= 3'h0;
      range_reg <= 3'h0;
      wr_reg    <= 1'b0;
      pend_reg  <= 1'b0;
    end else begin
      pend_reg <= xlat_valid;
      if (xlat_valid) begin
        sel_reg   <= sel_next;
        range_reg <= range_en_reg ? xlat_range_type : `PMT_TYPE_UC;
        wr_reg    <= xlat_is_write;
      end
    end
  end

  // ==========================================================
  // slot read and merge, always active
  // a table write lands at its access edge; a lookup latched in that cycle
  // already reads the new slot, so software drains lookups before a change
  wire [7:0] slot_sel  = table_reg[sel_reg*`PMT_SLOT_W +: `PMT_SLOT_W];
  wire [3:0] eff_w;

  pmt_merge u_merge (
    .table_type (slot_sel[2:0]),
    .range_type (range_reg),
    .eff_type   (eff_w)
  );

  // ==========================================================
  // cache policy per effective type
  reg        cach_n;
  reg        comb_n;
  reg        spec_n;
  reg  [1:0] alloc_n;
  reg        wmem_n;
  reg        wcache_n;
  reg        winv_n;
  always @* begin
    cach_n   = 1'b0;
    comb_n   = 1'b0;
    spec_n   = 1'b0;
    alloc_n  = `PMT_ALLOC_NONE;
    wmem_n   = wr_reg;
    wcache_n = 1'b0;
    winv_n   = 1'b0;
    case (eff_w)
      {1'b0, `PMT_TYPE_WC}: begin
        comb_n = 1'b1;
        spec_n = !wr_reg;
      end
      {1'b0, `PMT_TYPE_WT}: begin
        cach_n   = 1'b1;
        alloc_n  = wr_reg ? `PMT_ALLOC_NONE : `PMT_ALLOC_SHARED;
        wcache_n = wr_reg;
      end
      {1'b0, `PMT_TYPE_WP}: begin
        cach_n  = 1'b1;
        alloc_n = wr_reg ? `PMT_ALLOC_NONE : `PMT_ALLOC_SHARED;
        winv_n  = wr_reg;
      end
      {1'b0, `PMT_TYPE_WB}: begin
        cach_n   = 1'b1;
        alloc_n  = wr_reg ? `PMT_ALLOC_MODIFIED : `PMT_ALLOC_SH_EXCL;
        wmem_n   = 1'b0;
        wcache_n = wr_reg;
      end
      default: begin
        cach_n = 1'b0; // uc and cd: no cache, no combine, no speculation
      end
    endcase
  end

  // ==========================================================
  // registered answer, one cycle after the captured request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_valid       <= 1'b0;
      eff_type_out     <= 4'h0;
      table_type_out   <= 3'h0;
      cacheable_out    <= 1'b0;
      combine_ok_out   <= 1'b0;
      speculate_ok_out <= 1'b0;
      alloc_state_out  <= `PMT_ALLOC_NONE;
      write_mem_out    <= 1'b0;
      write_cache_out  <= 1'b0;
      write_inval_out  <= 1'b0;
    end else begin
      type_valid <= pend_reg;
      if (pend_reg) begin
        eff_type_out     <= eff_w;
        table_type_out   <= slot_sel[2:0];
        cacheable_out    <= cach_n;
        combine_ok_out   <= comb_n;
        speculate_ok_out <= spec_n;
        alloc_state_out  <= alloc_n;
        write_mem_out    <= wmem_n;
        write_cache_out  <= wcache_n;
        write_inval_out  <= winv_n;
      end
    end
  end

endmodule // pmt_resolver
`default_nettype wire

// [pmt_resolver_asserts.sv]
// port-level checks on the page memory type resolver
`timescale 1ns/10ps
`default_nettype none
module pmt_resolver_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        xlat_valid,
  input wire logic        xlat_is_write,
  input wire logic        type_valid,
  input wire logic [3:0]  eff_type_out,
  input wire logic        cacheable_out,
  input wire logic        combine_ok_out,
  input wire logic        speculate_ok_out,
  input wire logic [1:0]  alloc_state_out,
  input wire logic        write_mem_out,
  input wire logic        write_cache_out,
  input wire logic        write_inval_out,
  input wire logic        protection_fault
);
  // ==========================================================
  // lookup timing and cache policy
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_lookup_late: assert property (xlat_valid |-> ##2 type_valid)
    else $error("lookup answer late");
  chk_no_stray: assert property (type_valid |-> $past(xlat_valid, 2))
    else $error("stray lookup answer");
  chk_uc_uncached: assert property (type_valid && eff_type_out == 4'h0
    |-> !cacheable_out && !combine_ok_out && !speculate_ok_out) else $error("uncacheable access cached or combined");
  chk_wc_combine: assert property (type_valid && eff_type_out == 4'h1 |-> combine_ok_out && !cacheable_out)
    else $error("write-combining policy wrong");
  chk_wc_speculate: assert property (type_valid && eff_type_out == 4'h1
    |-> speculate_ok_out == !$past(xlat_is_write, 2)) else $error("write-combining speculation wrong");
  chk_wtwp_alloc: assert property (type_valid && eff_type_out inside {4'h4, 4'h5}
    |-> alloc_state_out == ($past(xlat_is_write, 2) ? 2'h0 : 2'h1)) else $error("wt or wp allocation wrong");
  chk_wp_write: assert property (type_valid && eff_type_out == 4'h5 && $past(xlat_is_write, 2)
    |-> write_inval_out && write_mem_out && !write_cache_out) else $error("wp write hit wrong");
  chk_wt_write: assert property (type_valid && eff_type_out == 4'h4 && $past(xlat_is_write, 2)
    |-> write_cache_out && write_mem_out && !write_inval_out) else $error("wt write hit wrong");
  chk_wb_alloc: assert property (type_valid && eff_type_out == 4'h6
    |-> alloc_state_out == ($past(xlat_is_write, 2) ? 2'h3 : 2'h2)) else $error("wb allocation wrong");
  // ==========================================================
  // register access
  chk_rsv_fault: assert property (psel && penable && pwrite && paddr == 12'h000 && pstrb[0]
    && pwdata[7:3] != 5'h0 |-> pslverr ##1 protection_fault) else $error("reserved bits accepted");
  chk_fault_cause: assert property (protection_fault |-> $past(psel && penable && pwrite && pslverr))
    else $error("fault without rejected write");
  chk_feature_bit: assert property (psel && penable && !pwrite && paddr == 12'h010 |-> prdata[16])
    else $error("feature bit clear");
endmodule // pmt_resolver_asserts

bind pmt_resolver pmt_resolver_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pslverr, .xlat_valid, .xlat_is_write, .type_valid, .eff_type_out, .cacheable_out, .combine_ok_out,
  .speculate_ok_out,
  .alloc_state_out, .write_mem_out, .write_cache_out, .write_inval_out, .protection_fault);
`default_nettype wire

// [pmt_walk_model.sv]
// page-table walker model issuing translation requests
`timescale 1ns/10ps
`default_nettype none
module pmt_walk_model (
  input  wire logic        pclk,
  output var  logic        xlat_valid,
  output var  logic [63:0] xlat_entry,
  output var  logic [1:0]  xlat_level,
  output var  logic [2:0]  xlat_range_type,
  output var  logic        xlat_is_write
);
  integer seed = 32'hba05;
  // ==========================================================
  // idle at time zero
  initial begin
    xlat_valid = 1'b0;
    xlat_entry = 64'h0;
    xlat_level = 2'h0;
    xlat_range_type = 3'h0;
    xlat_is_write = 1'b0;
  end
  // one request per call, back to back when called each cycle
  task automatic issue(input logic [2:0] idx, input logic [1:0] lvl, input logic [2:0] rt);
    logic [63:0] e;
    e = {$random(seed), $random(seed)};
    if (lvl == 2'h0) e[7] = idx[2];
    if (lvl == 2'h1) e[12] = idx[2];
    e[4] = idx[1];
    e[3] = idx[0];
    @(posedge pclk);
    xlat_valid <= 1'b1;
    xlat_entry <= e;
    xlat_level <= lvl;
    xlat_range_type <= rt;
    xlat_is_write <= e[40];
  endtask
  // drop the request and scramble the stale entry
  task automatic idle();
    @(posedge pclk);
    xlat_valid <= 1'b0;
    xlat_entry <= ~xlat_entry;
  endtask
endmodule // pmt_walk_model
`default_nettype wire

// [tb.sv]
// self-checking bench for the page memory type resolver
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ==========================================================
  // signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  wire         pready, pslverr, xv, xw, tv, pf;
  wire  [31:0] prdata;
  wire  [63:0] xe;
  wire  [1:0]  xl;
  wire  [2:0]  xr, tt;
  wire  [3:0]  eff;
  logic [2:0]  tbl [8];
  logic [2:0]  rng [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
  logic [6:0]  expq [$];
  logic [6:0]  nt;
  logic        ren = 1'b0;
  integer      error_cnt = 0;
  integer      checks_done = 0;
  always #25 pclk = ~pclk;
  pmt_walk_model u_walk (.pclk(pclk), .xlat_valid(xv), .xlat_entry(xe), .xlat_level(xl),
    .xlat_range_type(xr), .xlat_is_write(xw));
  pmt_resolver #(.ENTRY_W(64)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .xlat_valid(xv), .xlat_entry(xe), .xlat_level(xl), .xlat_range_type(xr),
    .xlat_is_write(xw), .type_valid(tv), .eff_type_out(eff), .table_type_out(tt), .cacheable_out(),
    .combine_ok_out(), .speculate_ok_out(), .alloc_state_out(), .write_mem_out(), .write_cache_out(),
    .write_inval_out(), .protection_fault(pf));
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", x, r & m);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic x);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("pslverr", {31'h0, x}, {31'h0, e});
    @(negedge pclk);
    chk("protection_fault", {31'h0, x}, {31'h0, pf});
  endtask
  function automatic logic [3:0] mrg(input logic [2:0] t, input logic [2:0] r);
    case (t)
      3'h0: mrg = (r == 3'h0) ? 4'h0 : 4'h8;
      3'h7: mrg = (r < 3'h2) ? {1'b0, r} : 4'h8;
      3'h1: mrg = 4'h1;
      3'h5: mrg = (r == 3'h0) ? 4'h0 : (r == 3'h1 || r == 3'h4) ? 4'h8 : 4'h5;
      3'h4: mrg = (r == 3'h0) ? 4'h0 : (r == 3'h1 || r == 3'h5) ? 4'h8 : 4'h4;
      default: mrg = {1'b0, r};
    endcase
  endfunction
  task automatic lk(input logic [2:0] i, input logic [1:0] l, input logic [2:0] rt);
    logic [2:0] s;
    s = (l > 2'h1) ? {1'b0, i[1:0]} : i;
    expq.push_back({tbl[s], mrg(tbl[s], ren ? rt : 3'h0)});
    u_walk.issue(i, l, rt);
  endtask
  task automatic drain();
    integer n;
    u_walk.idle();
    n = 0;
    while (expq.size() != 0 && n < 10) begin @(posedge pclk); n++; end
    if (expq.size() != 0) begin error_cnt++; close_out(); end
  endtask
  // compare each lookup answer with the oldest note
  always @(negedge pclk) begin
    if (tv === 1'b1) begin
      if (expq.size() == 0) chk("type_valid", 0, 1);
      else begin
        nt = expq.pop_front();
        chk("eff_type_out", {28'h0, nt[3:0]}, {28'h0, eff});
        chk("table_type_out", {29'h0, nt[6:4]}, {29'h0, tt});
      end
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    integer i, j;
    tbl = '{3'h6, 3'h4, 3'h7, 3'h0, 3'h6, 3'h4, 3'h7, 3'h0};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h00070406, 32'hffffffff, 1'b0);
    rd(12'h004, 32'h00070406, 32'hffffffff, 1'b0);
    rd(12'h010, 32'h00010000, 32'h00010000, 1'b0);
    rd(12'h020, 32'h0, 32'hffffffff, 1'b1);
    for (i = 0; i < 8; i++) lk(i[2:0], i[1:0], 3'h6);
    drain();
    wr(12'h000, 32'h05040100, 1'b0);
    wr(12'h004, 32'h00000706, 1'b0);
    wr(12'h00c, 32'h00000008, 1'b0);
    tbl = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h0};
    ren = 1'b1;
    for (i = 0; i < 6; i++)
      for (j = 0; j < 5; j++) lk((j[1] && !j[2]) ? {1'b1, i[1:0]} : i[2:0],
                                 (i > 3) ? {1'b0, j[0]} : j[1:0], rng[j]);
    drain();
    wr(12'h000, 32'h05040108, 1'b1);
    wr(12'h004, 32'h00000206, 1'b1);
    rd(12'h000, 32'h05040100, 32'hffffffff, 1'b0);
    rd(12'h004, 32'h00000706, 32'hffffffff, 1'b0);
    rd(12'h008, 32'h00000001, 32'h00000003, 1'b0);
    wr(12'h008, 32'h00000001, 1'b0);
    rd(12'h008, 32'h00000000, 32'h00000003, 1'b0);
    close_out();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
endmodule // tb
`default_nettype wire
